// ### core/pmcg_top.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pmcg_defs.svh"
module pmcg_top (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [11:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic WATCHDOG_CLOCK_SELECT,
    input wire logic WDT_IRQ,
    input wire logic WDT_RST,
    input wire logic EXT_IRQ_A,
    input wire logic EXT_IRQ_B,
    input wire logic EXT_A_LEVEL_MODE,
    input wire logic EXT_B_LEVEL_MODE,
    input wire logic KEYBOARD_IRQ,
    input wire logic RTC_IRQ,
    input wire logic COMPARATOR_IRQ,
    input wire logic BROWNOUT_DETECT,
    input wire logic IRQ_ANY,
    input wire logic RC_IS_SYSCLK,
    input wire logic RTC_USES_XTAL,
    input wire logic CAPTURE_UNIT_DISABLE_CFG,
    input wire logic UART_MODE_BIT,
    input wire logic UART_FRAMING_ERROR,
    input wire logic T1_OVERFLOW,
    output logic SERIAL_BIT7_RDATA,
    output logic FRAMING_ERROR_VIEW,
    output logic UART_BAUD_TICK,
    output logic BROWNOUT_IRQ_REQ,
    output logic BROWNOUT_DETECT_OFF,
    output logic COMPARATOR_FORCE_OFF,
    output logic SYS_OSC_STOP,
    output logic RC_OSC_RUN,
    output logic XTAL_RTC_KEEP,
    output logic CPU_IDLE,
    output logic CAPTURE_UNIT_CLOCK_OFF,
    output logic UART_CLOCK_OFF,
    output logic SPI_CLOCK_OFF,
    output logic I2C_CLOCK_OFF,
    output logic ADC_CLOCK_OFF,
    output logic COMPARATOR_POWER_OFF,
    output logic EEPROM_POWER_OFF,
    output logic RTC_CLOCK_OFF,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    // Current power state.
    pmcg_pkg::pmcg_state_t state_r;
    // User flags, interrupt enable and serial option bits.
    logic user_flag_a_r;
    logic user_flag_b_r;
    logic brownout_irq_enable_r;
    logic framing_error_view_r;
    logic baud_double_r;
    // Peripheral power control byte.
    logic [7:0] periph_r;
    // Interrupt mask, same layout as status.
    logic [`PMCG_EVT_W-1:0] mask_r;
    logic [`PMCG_EVT_W-1:0] status;
    logic [`PMCG_EVT_W-1:0] evt_set;
    logic [`PMCG_EVT_W-1:0] evt_clr;
    // Bus handshake and read path.
    logic ack_r;
    logic [7:0] rd_nxt;
    logic [7:0] rd_r;
    logic [`PMCG_IDX_W-1:0] idx;
    logic req;
    logic wr_take;
    logic rd_take;
    logic wr_pwr;
    logic wr_periph;
    logic wr_mask;
    // Wake decode.
    logic pd_any;
    logic in_idle;
    logic pd_wake;
    logic wake_now;
    // Baud halving phase.
    logic half_r;
    // Gate outputs from the per-peripheral gate flops.
    logic [7:0] gate_off;
    logic [7:0] extra_off;
    localparam logic [7:0] FORCE_MASK = `PMCG_PD_FORCE;

    // Map a written field code onto a state.
    function automatic pmcg_pkg::pmcg_state_t sel_to_state(input logic [1:0] sel);
        pmcg_pkg::pmcg_state_t s;
        s = pmcg_pkg::PMCG_RUN;
        unique case (sel)
            `PMCG_SEL_RUN: s = pmcg_pkg::PMCG_RUN;
            `PMCG_SEL_IDLE: s = pmcg_pkg::PMCG_IDLE;
            `PMCG_SEL_PD: s = pmcg_pkg::PMCG_PD;
            `PMCG_SEL_TPD: s = pmcg_pkg::PMCG_TPD;
        endcase
        return s;
    endfunction : sel_to_state

    // Map the state back onto the field code software reads.
    function automatic logic [1:0] state_to_sel(input pmcg_pkg::pmcg_state_t s);
        logic [1:0] v;
        v = `PMCG_SEL_RUN;
        unique case (s)
            pmcg_pkg::PMCG_RUN: v = `PMCG_SEL_RUN;
            pmcg_pkg::PMCG_IDLE: v = `PMCG_SEL_IDLE;
            pmcg_pkg::PMCG_PD: v = `PMCG_SEL_PD;
            pmcg_pkg::PMCG_TPD: v = `PMCG_SEL_TPD;
        endcase
        return v;
    endfunction : state_to_sel

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave.

    // Word index; the two low address bits are ignored.
    assign idx = WB_ADR_I[11:2];
    assign req = WB_CYC_I & WB_STB_I;
    // A write lands at the edge where the master sees ack.
    assign wr_take = req & WB_WE_I & ack_r & WB_SEL_I[0];
    assign rd_take = req & ~WB_WE_I & ack_r;
    assign wr_pwr = wr_take & (idx == `PMCG_IDX_PWR);
    assign wr_periph = wr_take & (idx == `PMCG_IDX_PERIPH);
    assign wr_mask = wr_take & (idx == `PMCG_IDX_MASK);

    // Ack one cycle after the request, dropped the cycle after.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        rd_nxt = `PMCG_RST_BYTE;
        unique case (idx)
            `PMCG_IDX_PWR: begin
                rd_nxt[`PMCG_PC_SEL_HI:`PMCG_PC_SEL_LO] = state_to_sel(state_r);
                rd_nxt[`PMCG_PC_FLAG_A] = user_flag_a_r;
                rd_nxt[`PMCG_PC_FLAG_B] = user_flag_b_r;
                rd_nxt[`PMCG_PC_BOI] = brownout_irq_enable_r;
                rd_nxt[`PMCG_PC_RSVD] = 1'b0;
                rd_nxt[`PMCG_PC_VIEW] = framing_error_view_r;
                rd_nxt[`PMCG_PC_BAUD] = baud_double_r;
            end
            `PMCG_IDX_PERIPH: begin
                rd_nxt = periph_r;
            end
            `PMCG_IDX_STATUS: begin
                rd_nxt[`PMCG_EVT_W-1:0] = status;
            end
            `PMCG_IDX_MASK: begin
                rd_nxt[`PMCG_EVT_W-1:0] = mask_r;
            end
            default: begin
                rd_nxt = `PMCG_RST_BYTE;
            end
        endcase
    end

    // Read data is captured as ack rises and held while ack stands.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rd_r <= `PMCG_RST_BYTE;
        end else if (req & ~ack_r) begin
            rd_r <= rd_nxt;
        end
    end

    assign WB_DAT_O = {24'h00_0000, rd_r};
    assign WB_ACK_O = ack_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Flags and serial options; bit 5 has no storage at all.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            user_flag_a_r <= 1'b0;
            user_flag_b_r <= 1'b0;
            brownout_irq_enable_r <= 1'b0;
            framing_error_view_r <= 1'b0;
            baud_double_r <= 1'b0;
        end else if (wr_pwr) begin
            user_flag_a_r <= WB_DAT_I[`PMCG_PC_FLAG_A];
            user_flag_b_r <= WB_DAT_I[`PMCG_PC_FLAG_B];
            brownout_irq_enable_r <= WB_DAT_I[`PMCG_PC_BOI];
            framing_error_view_r <= WB_DAT_I[`PMCG_PC_VIEW];
            baud_double_r <= WB_DAT_I[`PMCG_PC_BAUD];
        end
    end

    // Peripheral power byte; comparator ordering is software's duty.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            periph_r <= `PMCG_RST_BYTE;
        end else if (wr_periph) begin
            periph_r <= WB_DAT_I[7:0];
        end
    end

    // Interrupt mask.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            mask_r <= `PMCG_RST_EVT;
        end else if (wr_mask) begin
            mask_r <= WB_DAT_I[`PMCG_EVT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power state and wake-up.

    assign pd_any = (state_r == pmcg_pkg::PMCG_PD) | (state_r == pmcg_pkg::PMCG_TPD);
    assign in_idle = (state_r == pmcg_pkg::PMCG_IDLE);

    // Wake sources valid in power-down. Brownout and comparator trips
    // cannot wake from total power-down since both circuits are off there.
    assign pd_wake = (WATCHDOG_CLOCK_SELECT & (WDT_IRQ | WDT_RST))
        | (EXT_IRQ_A & EXT_A_LEVEL_MODE) | (EXT_IRQ_B & EXT_B_LEVEL_MODE)
        | KEYBOARD_IRQ
        | (RTC_IRQ & ~periph_r[`PMCG_PP_RTC])
        | ((state_r == pmcg_pkg::PMCG_PD) & (BROWNOUT_DETECT | COMPARATOR_IRQ));

    // Idle ends on any enabled interrupt; power-down only on its sources.
    assign wake_now = (pd_any & pd_wake) | (in_idle & (IRQ_ANY | pd_wake));

    // Wake wins over a write in the same cycle, since a stopped CPU
    // cannot have meant to re-enter a mode it is leaving.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_r <= pmcg_pkg::PMCG_RUN;
        end else if (wake_now) begin
            state_r <= pmcg_pkg::PMCG_RUN;
        end else if (wr_pwr) begin
            state_r <= sel_to_state(WB_DAT_I[`PMCG_PC_SEL_HI:`PMCG_PC_SEL_LO]);
        end
    end

    // Oscillator, brownout and comparator controls follow the state.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            SYS_OSC_STOP <= 1'b0;
            RC_OSC_RUN <= 1'b1;
            XTAL_RTC_KEEP <= 1'b0;
            BROWNOUT_DETECT_OFF <= 1'b0;
            COMPARATOR_FORCE_OFF <= 1'b0;
            CPU_IDLE <= 1'b0;
        end else begin
            SYS_OSC_STOP <= pd_any;
            RC_OSC_RUN <= ~pd_any | (RC_IS_SYSCLK & ~periph_r[`PMCG_PP_RTC]);
            XTAL_RTC_KEEP <= pd_any & RTC_USES_XTAL & ~periph_r[`PMCG_PP_RTC];
            BROWNOUT_DETECT_OFF <= (state_r == pmcg_pkg::PMCG_TPD);
            COMPARATOR_FORCE_OFF <= (state_r == pmcg_pkg::PMCG_TPD);
            CPU_IDLE <= in_idle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial-port options and brownout interrupt.

    // Bit 7 view mux and the steering level for serial writes.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            SERIAL_BIT7_RDATA <= 1'b0;
            FRAMING_ERROR_VIEW <= 1'b0;
        end else begin
            SERIAL_BIT7_RDATA <= framing_error_view_r ? UART_FRAMING_ERROR : UART_MODE_BIT;
            FRAMING_ERROR_VIEW <= framing_error_view_r;
        end
    end

    // Halving passes every second overflow; the phase is kept even
    // while doubling so switching modes loses at most one tick.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            half_r <= 1'b0;
            UART_BAUD_TICK <= 1'b0;
        end else begin
            if (T1_OVERFLOW) begin
                half_r <= ~half_r;
            end
            UART_BAUD_TICK <= T1_OVERFLOW & (baud_double_r | half_r);
        end
    end

    // Brownout request; no detection runs in total power-down.
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            BROWNOUT_IRQ_REQ <= 1'b0;
        end else begin
            BROWNOUT_IRQ_REQ <= brownout_irq_enable_r & BROWNOUT_DETECT
                & (state_r != pmcg_pkg::PMCG_TPD);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Events and interrupt.

    // Only the bits actually returned are cleared by a status read.
    assign evt_clr = (rd_take & (idx == `PMCG_IDX_STATUS)) ? rd_r[`PMCG_EVT_W-1:0]
        : `PMCG_RST_EVT;

    always_comb begin
        evt_set = `PMCG_RST_EVT;
        evt_set[`PMCG_EVT_BOD] = brownout_irq_enable_r & BROWNOUT_DETECT
            & (state_r != pmcg_pkg::PMCG_TPD);
        evt_set[`PMCG_EVT_PDWAKE] = pd_any & wake_now;
        evt_set[`PMCG_EVT_IDLEWAKE] = in_idle & wake_now;
    end

    pmcg_sticky #(
        .W(`PMCG_EVT_W)
    ) u_sticky (
        .clk(MCLK),
        .rst(SYS_RST),
        .set(evt_set),
        .clr(evt_clr),
        .mask(mask_r),
        .status(status),
        .irq(IRQ)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Peripheral gates.

    // Only the capture unit has an extra off condition.
    always_comb begin
        extra_off = `PMCG_RST_BYTE;
        extra_off[`PMCG_PP_CCU] = CAPTURE_UNIT_DISABLE_CFG;
    end

    // One gate flop per peripheral; the mask picks which obey power-down.
    for (genvar g = 0; g < 8; g++) begin : g_gate
        pmcg_gate #(
            .FORCE_IN_PD(FORCE_MASK[g])
        ) u_gate (
            .clk(MCLK),
            .rst(SYS_RST),
            .off_bit(periph_r[g]),
            .extra_off(extra_off[g]),
            .pd_any(pd_any),
            .gate_off(gate_off[g])
        );
    end

    assign CAPTURE_UNIT_CLOCK_OFF = gate_off[`PMCG_PP_CCU];
    assign UART_CLOCK_OFF = gate_off[`PMCG_PP_UART];
    assign SPI_CLOCK_OFF = gate_off[`PMCG_PP_SPI];
    assign I2C_CLOCK_OFF = gate_off[`PMCG_PP_I2C];
    assign ADC_CLOCK_OFF = gate_off[`PMCG_PP_ADC];
    assign COMPARATOR_POWER_OFF = gate_off[`PMCG_PP_COMP];
    assign EEPROM_POWER_OFF = gate_off[`PMCG_PP_EEPROM];
    assign RTC_CLOCK_OFF = gate_off[`PMCG_PP_RTC];

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    a_wd_wake: assert property (
        (state_r == pmcg_pkg::PMCG_PD) && WATCHDOG_CLOCK_SELECT && (WDT_IRQ || WDT_RST)
        |=> state_r == pmcg_pkg::PMCG_RUN
    ) else $error("watchdog did not wake");

    a_ext_wake: assert property (
        pd_any && ((EXT_IRQ_A && EXT_A_LEVEL_MODE) || KEYBOARD_IRQ)
        |=> state_r == pmcg_pkg::PMCG_RUN
    ) else $error("external or keyboard did not wake");

    a_rtc_wake: assert property (
        pd_any && RTC_IRQ && !periph_r[`PMCG_PP_RTC] |=> state_r == pmcg_pkg::PMCG_RUN
    ) else $error("rtc did not wake");

    a_mode_write: assert property (
        wr_pwr && !wake_now && (WB_DAT_I[1:0] == `PMCG_SEL_PD)
        |=> state_r == pmcg_pkg::PMCG_PD ##1 SYS_OSC_STOP
    ) else $error("power-down entry wrong");

    a_tpd_bod: assert property (
        state_r == pmcg_pkg::PMCG_TPD |=> BROWNOUT_DETECT_OFF && COMPARATOR_FORCE_OFF
    ) else $error("total power-down left brownout on");

    a_osc_stop: assert property (
        pd_any && !(RC_IS_SYSCLK && !periph_r[`PMCG_PP_RTC]) |=> SYS_OSC_STOP && !RC_OSC_RUN
    ) else $error("oscillator not stopped");

    a_flags_keep: assert property (
        wr_pwr |=> {user_flag_b_r, user_flag_a_r} == $past(WB_DAT_I[3:2])
    ) else $error("user flags not stored");

    a_bod_irq: assert property (
        BROWNOUT_DETECT && brownout_irq_enable_r && (state_r != pmcg_pkg::PMCG_TPD)
        |=> BROWNOUT_IRQ_REQ ##1 status[`PMCG_EVT_BOD]
    ) else $error("brownout request missing");

    a_fe_view: assert property (
        ##1 SERIAL_BIT7_RDATA == $past(framing_error_view_r ? UART_FRAMING_ERROR : UART_MODE_BIT)
    ) else $error("serial bit 7 view wrong");

    a_baud_half: assert property (
        T1_OVERFLOW && !baud_double_r && !half_r |=> !UART_BAUD_TICK
    ) else $error("baud tick not halved");

    a_ccu_gate: assert property (
        (pd_any || CAPTURE_UNIT_DISABLE_CFG || periph_r[`PMCG_PP_CCU]) |=> CAPTURE_UNIT_CLOCK_OFF
    ) else $error("capture clock not off");

    a_pd_gates: assert property (
        pd_any |=> UART_CLOCK_OFF && SPI_CLOCK_OFF && I2C_CLOCK_OFF && EEPROM_POWER_OFF
    ) else $error("power-down gate not off");

    a_adc_gate: assert property (
        ##1 ADC_CLOCK_OFF == $past(periph_r[`PMCG_PP_ADC])
    ) else $error("adc gate wrong");

    a_rtc_gate: assert property (
        ##1 RTC_CLOCK_OFF == $past(periph_r[`PMCG_PP_RTC])
    ) else $error("rtc gate wrong");

    a_rsvd_zero: assert property (
        ack_r && (idx == `PMCG_IDX_PWR) |-> !WB_DAT_O[`PMCG_PC_RSVD]
    ) else $error("reserved bit reads one");

    a_ack_pulse: assert property (
        ack_r |=> !ack_r
    ) else $error("ack held two cycles");

    c_pd_enter: cover property (state_r == pmcg_pkg::PMCG_RUN ##1 state_r == pmcg_pkg::PMCG_PD);
    c_pd_wake: cover property (state_r == pmcg_pkg::PMCG_TPD ##1 state_r == pmcg_pkg::PMCG_RUN);
    c_bod_irq: cover property (BROWNOUT_IRQ_REQ ##1 IRQ);
    c_stat_read: cover property (rd_take && (idx == `PMCG_IDX_STATUS) && (rd_r != 8'h00));

endmodule : pmcg_top
`default_nettype wire

// ### core/pmcg_defs.svh
// How it works
// - Watchdog on own clock wakes from power-down
// - Level external pins and keyboard wake device
// - Real-time clock wakes unless its clock off
// - Power-mode field sits in bits 1:0
// - Modes: run, idle, power-down, total power-down
// - Power-down stops oscillator; RC may keep running
// - Bits 2 and 3 are free user flags
// - Bit 4 enables the brownout interrupt request
// - Bit 6 steers serial bit 7 view
// - Bit 7 passes or halves baud ticks
// - Capture unit clock off by bit/mode/config
// - UART clock off by bit or power-down
// - SPI clock off by bit or power-down
// - I2C clock off by bit or power-down
// - Bit 4 stops the converter clock
// - EEPROM off by bit or power-down
// - Bit 7 gates the real-time clock off
`ifndef PMCG_DEFS_SVH
`define PMCG_DEFS_SVH

// Register indices; the byte address is four times the index.
`define PMCG_IDX_W 10
`define PMCG_IDX_PWR 10'h087
`define PMCG_IDX_PERIPH 10'h0b5
`define PMCG_IDX_STATUS 10'h0c0
`define PMCG_IDX_MASK 10'h0c1

// Power control field positions.
`define PMCG_PC_SEL_HI 1
`define PMCG_PC_SEL_LO 0
`define PMCG_PC_FLAG_A 2
`define PMCG_PC_FLAG_B 3
`define PMCG_PC_BOI 4
`define PMCG_PC_RSVD 5
`define PMCG_PC_VIEW 6
`define PMCG_PC_BAUD 7

// Peripheral power control bit positions.
`define PMCG_PP_CCU 0
`define PMCG_PP_UART 1
`define PMCG_PP_SPI 2
`define PMCG_PP_I2C 3
`define PMCG_PP_ADC 4
`define PMCG_PP_COMP 5
`define PMCG_PP_EEPROM 6
`define PMCG_PP_RTC 7

// Gates that both power-down modes force off.
`define PMCG_PD_FORCE 8'h4f

// Power-mode field codes.
`define PMCG_SEL_RUN 2'h0
`define PMCG_SEL_IDLE 2'h1
`define PMCG_SEL_PD 2'h2
`define PMCG_SEL_TPD 2'h3

// Event status bits.
`define PMCG_EVT_W 3
`define PMCG_EVT_BOD 0
`define PMCG_EVT_PDWAKE 1
`define PMCG_EVT_IDLEWAKE 2

// Reset values.
`define PMCG_RST_BYTE 8'h00
`define PMCG_RST_EVT 3'h0

`endif

// ### core/pmcg_pkg.sv
package pmcg_pkg;
    // Power state, Gray coded along run, idle, power-down, total power-down.
    typedef enum logic [1:0] {
        PMCG_RUN = 2'h0,
        PMCG_IDLE = 2'h1,
        PMCG_PD = 2'h3,
        PMCG_TPD = 2'h2
    } pmcg_state_t;
endpackage : pmcg_pkg

// ### core/pmcg_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmcg_defs.svh"
module pmcg_gate #(
    parameter bit FORCE_IN_PD = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic off_bit,
    input wire logic extra_off,
    input wire logic pd_any,
    output logic gate_off
);
    // Registered so the gate never glitches on a decode race.
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_off <= 1'b0;
        end else begin
            gate_off <= off_bit | extra_off | (FORCE_IN_PD & pd_any);
        end
    end
endmodule : pmcg_gate
`default_nettype wire

// ### core/pmcg_sticky.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmcg_defs.svh"
module pmcg_sticky #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    input wire logic [W-1:0] mask,
    output logic [W-1:0] status,
    output logic irq
);
    // Set wins over clear, so an event in the clearing cycle survives.
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
        end else begin
            status <= (status & ~clr) | set;
        end
    end

    // Level interrupt while any unmasked bit stands.
    assign irq = |(status & mask);
endmodule : pmcg_sticky
`default_nettype wire

// ### sim/pmcg_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module pmcg_top_test;
    // Byte addresses of the four registers.
    localparam logic [11:0] A_PC = 12'h21c;
    localparam logic [11:0] A_PP = 12'h2d4;
    localparam logic [11:0] A_ST = 12'h300;
    localparam logic [11:0] A_MK = 12'h304;
    // Every input holds a defined value from time zero.
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, t1 = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h1;
    logic [31:0] dw = 32'h0000_0000;
    logic [15:0] ev = 16'h0000; // Side-band request pins, one bit each except ev[14], which drives both brownout and comparator.
    logic [31:0] dr;
    logic ack, bit7, fev, tick, boreq, booff, cmpoff, oscstop, rcrun, xkeep, idle, irq;
    logic [7:0] gates; // Gate outputs, bit order as in the peripheral register.
    int num_errors = 0, samples_checked = 0, cycles = 0, ticks = 0, t0, i;
    // Wake table: pins raised in power-down and the mode field expected after.
    logic [15:0] wk [0:10] = '{16'h0003, 16'h0005, 16'h0028, 16'h0050, 16'h0080,
                               16'h0100, 16'h0002, 16'h0008, 16'h0010, 16'h0100, 16'h4000};
    logic [7:0] wm [0:10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02,
                              8'h02, 8'h02, 8'h00};
    pmcg_top pmcg_top_i (.MCLK(mclk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr),
        .WB_ACK_O(ack), .WATCHDOG_CLOCK_SELECT(ev[0]), .WDT_IRQ(ev[1]), .WDT_RST(ev[2]),
        .EXT_IRQ_A(ev[3]), .EXT_IRQ_B(ev[4]), .EXT_A_LEVEL_MODE(ev[5]),
        .EXT_B_LEVEL_MODE(ev[6]), .KEYBOARD_IRQ(ev[7]), .RTC_IRQ(ev[8]),
        .COMPARATOR_IRQ(ev[14]), .BROWNOUT_DETECT(ev[14]), .IRQ_ANY(ev[15]),
        .RC_IS_SYSCLK(ev[9]), .RTC_USES_XTAL(ev[10]), .CAPTURE_UNIT_DISABLE_CFG(ev[11]),
        .UART_MODE_BIT(ev[12]), .UART_FRAMING_ERROR(ev[13]), .T1_OVERFLOW(t1),
        .SERIAL_BIT7_RDATA(bit7), .FRAMING_ERROR_VIEW(fev), .UART_BAUD_TICK(tick),
        .BROWNOUT_IRQ_REQ(boreq), .BROWNOUT_DETECT_OFF(booff), .COMPARATOR_FORCE_OFF(cmpoff),
        .SYS_OSC_STOP(oscstop), .RC_OSC_RUN(rcrun), .XTAL_RTC_KEEP(xkeep), .CPU_IDLE(idle),
        .CAPTURE_UNIT_CLOCK_OFF(gates[0]), .UART_CLOCK_OFF(gates[1]),
        .SPI_CLOCK_OFF(gates[2]), .I2C_CLOCK_OFF(gates[3]), .ADC_CLOCK_OFF(gates[4]),
        .COMPARATOR_POWER_OFF(gates[5]), .EEPROM_POWER_OFF(gates[6]),
        .RTC_CLOCK_OFF(gates[7]), .IRQ(irq));
    // Free-running 250 MHz clock.
    initial begin
        forever #2 mclk = ~mclk;
    end
    // Counts baud ticks mid-cycle, where the pulse is settled, and cuts a hang short.
    always @(negedge mclk) begin
        cycles++;
        if (tick === 1'b1) ticks++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] r);
        int n;
        logic hit;
        n = 0;
        hit = 1'b0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= {24'h00_0000, d};
        // Ack and data are looked at mid-cycle, where they are settled; the
        // rising edge that follows is the one at which the slave sees ack high.
        do begin
            @(negedge mclk);
            n++;
            hit = (ack === 1'b1);
            r = dr[7:0];
            @(posedge mclk);
        end while (!hit && n < 50);
        if (!hit) num_errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] r;
        wb(1'b0, a, 8'h00, r);
        chk(r, e);
    endtask : rd
    // Single compare; one-bit results arrive zero-extended, unknowns still fail.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) @(posedge mclk);
    endtask : cy
    // Overflow pulses, one cycle high each, with a quiet cycle between.
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge mclk);
            t1 <= 1'b1;
            @(posedge mclk);
            t1 <= 1'b0;
        end
        cy(2);
    endtask : pulse
    task automatic summarize();
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd(A_PC, 8'h00);
        rd(A_PP, 8'h00);
        chk(rcrun, 8'h01);
        wr(A_PC, 8'hfc);
        rd(A_PC, 8'hdc);
        sel <= 4'h0;
        wr(A_PC, 8'h00);
        sel <= 4'h1;
        rd(A_PC, 8'hdc);
        wr(A_PC, 8'h00);
        wr(12'h010, 8'hff);
        rd(12'h010, 8'h00);
        $display("registers done");
        for (i = 0; i < 8; i++) begin
            wr(A_PP, 8'h01 << i);
            cy(2);
            chk(gates, 8'h01 << i);
        end
        wr(A_PP, 8'h00);
        ev[11] <= 1'b1;
        cy(2);
        chk(gates, 8'h01);
        ev[11] <= 1'b0;
        $display("gates done");
        // Power-down: forced gates, clocks, wake by keyboard and the interrupt.
        ev[10:9] <= 2'b11;
        wr(A_MK, 8'h02);
        wr(A_PC, 8'h02);
        cy(2);
        chk(gates, 8'h4f);
        chk(oscstop, 8'h01);
        chk(rcrun, 8'h01);
        chk(xkeep, 8'h01);
        rd(A_PC, 8'h02);
        ev[7] <= 1'b1;
        cy(2);
        ev[7] <= 1'b0;
        cy(1);
        chk(irq, 8'h01);
        rd(A_PC, 8'h00);
        rd(A_ST, 8'h02);
        cy(1);
        chk(irq, 8'h00);
        // Each wake source in turn, with masked interrupt.
        wr(A_MK, 8'h00);
        for (i = 0; i < 11; i++) begin
            wr(A_PP, (i == 9) ? 8'h80 : 8'h00);
            wr(A_PC, 8'h02);
            ev <= ev | wk[i];
            cy(3);
            chk(rcrun, {7'h00, i != 9});
            ev <= ev & ~wk[i];
            rd(A_PC, wm[i]);
        end
        chk(irq, 8'h00);
        wr(A_PP, 8'h00);
        wr(A_PC, 8'h00);
        wr(A_MK, 8'h02);
        cy(2);
        chk(irq, 8'h01);
        $display("power-down done");
        // Idle, woken by any enabled interrupt.
        wr(A_PC, 8'h01);
        cy(2);
        chk(idle, 8'h01);
        ev[15] <= 1'b1;
        cy(2);
        ev[15] <= 1'b0;
        rd(A_PC, 8'h00);
        // Total power-down masks brownout; run mode passes it.
        ev[14] <= 1'b1;
        wr(A_PC, 8'h13);
        cy(2);
        chk(boreq, 8'h00);
        chk({booff, cmpoff}, 8'h03);
        rd(A_PC, 8'h13);
        wr(A_PC, 8'h10);
        cy(2);
        chk(boreq, 8'h01);
        wr(A_PC, 8'h00);
        cy(2);
        chk(boreq, 8'h00);
        ev[14] <= 1'b0;
        rd(A_ST, 8'h07);
        $display("modes done");
        // Serial bit 7 steering, then baud halving and passing.
        ev[12] <= 1'b1;
        cy(2);
        chk(bit7, 8'h01);
        wr(A_PC, 8'h40);
        cy(2);
        chk({fev, bit7}, 8'h02);
        wr(A_PC, 8'h00);
        t0 = ticks;
        pulse(4);
        chk(8'(ticks - t0), 8'h02);
        wr(A_PC, 8'h80);
        t0 = ticks;
        pulse(4);
        chk(8'(ticks - t0), 8'h04);
        $display("serial done");
        summarize();
    end
endmodule : pmcg_top_test
`default_nettype wire
